// file: hdl/mifd_decoder.sv
// instruction field decoder with four-phase cycle timing and skip/branch flush
`timescale 1ns/1ps
module mifd_decoder
    import mifd_pkg::*;
(
    input wire logic mclk_in,
    input wire logic nrst_in,
    input wire logic [WORD_W-1:0] instr_in,
    input wire logic cond_true_in,
    input wire logic prescaler_on_timer_in,
    output mifd_fields_s fields_out,
    output mifd_flags_s flags_out,
    output logic cycle_end_out,
    output logic exec_valid_out,
    output logic flush_out,
    output logic sleep_req_out,
    output logic timeout_flag_out,
    output logic power_down_flag_out,
    output logic pc_inc_out
);
    // ==========================================================
    // state
    // one instruction cycle is OSC_PER_CYC clocks; the phase counter is the
    // divider, and its last phase is the one edge where a word is taken
    //   c0..c2 after release: idle phases, inputs are not looked at
    //   c3: instr_in, cond_true_in and prescaler_on_timer_in are sampled
    //   c4: pulses show for one clock, fields hold for the next four
    //   c8: after a taken skip, flush_out pulses and exec_valid_out stays low
    // a taken skip or pc change turns the following instruction cycle into a
    // discarded slot, so the prefetched word never reaches the outputs
    // fields are not qualified by class: a consumer ignores what its class
    // does not use, which keeps the split down to plain wiring
    // one packed struct holds all state of the module
    typedef struct packed {
        logic [1:0] phase;
        mifd_state_e st;
        mifd_fields_s fields;
        mifd_flags_s flags;
        logic cyc_end;
        logic exec_valid;
        logic flush;
        logic sleep_req;
        logic timeout_flag;
        logic power_down_flag;
        logic pc_inc;
    } mifd_regs_s;

    // registered state and its next value
    mifd_regs_s cur_ff;
    mifd_regs_s nxt_cur;

    // raw decode of the word now on instr_in
    mifd_fields_s dec_fields;
    mifd_flags_s dec_flags;

    // ==========================================================
    // decode helpers
    // phase and state qualifiers
    logic at_sample;
    logic in_fetch;
    // per-word outcomes
    logic take_second;
    logic prescale_go;
    logic standby_go;
    logic wdog_go;

    // word split is purely combinational; only the sample edge registers it
    mifd_field_split i_mifd_field_split
    (
        .word_in(instr_in),
        .fields_out(dec_fields),
        .flags_out(dec_flags)
    );

    // enable pulse from the divider: last oscillator period of the cycle
    assign at_sample = (cur_ff.phase == PHASE_LAST);
    // in_fetch is low only in the slot after a taken skip or pc change
    assign in_fetch = (cur_ff.st == MIFD_FETCH);

    // taken skip or pc change costs a second cycle; an untaken skip does not
    assign take_second = dec_flags.is_pc_write
        || (dec_flags.is_cond_skip && cond_true_in);

    // prescaler clear only counts if assigned to the timer
    assign prescale_go = dec_flags.clr_prescale && prescaler_on_timer_in;

    // status side effects only for a word that really executes, never in a
    // discarded slot, since the dropped word must leave no trace
    assign standby_go = at_sample && in_fetch && dec_flags.is_sleep;
    assign wdog_go = at_sample && in_fetch && dec_flags.is_wdog_clr;

    // ==========================================================
    // next-state logic
    always_comb
    begin
        // fields and levels hold between samples; pulses default low
        // exec_valid and flush never rise together, the state picks one
        nxt_cur = cur_ff;
        nxt_cur.cyc_end = 1'b0;
        nxt_cur.exec_valid = 1'b0;
        nxt_cur.flush = 1'b0;
        nxt_cur.sleep_req = 1'b0;
        nxt_cur.pc_inc = 1'b0;

        // divider wraps on its own width, one count per oscillator period
        nxt_cur.phase = 2'(cur_ff.phase + 2'h1);

        // decode is latched once per instruction cycle, at the last phase
        if (at_sample)
        begin
            // every cycle end advances the program counter, slot or not
            nxt_cur.cyc_end = 1'b1;
            nxt_cur.pc_inc = 1'b1;
            // the state picks between a real word and a discarded slot
            unique case (cur_ff.st)
                MIFD_FETCH:
                begin
                    // the whole word is taken at one edge, no partial fields
                    nxt_cur.fields = dec_fields;
                    nxt_cur.flags = dec_flags;
                    nxt_cur.flags.clr_prescale = prescale_go;
                    nxt_cur.exec_valid = 1'b1;
                    nxt_cur.sleep_req = dec_flags.is_sleep;
                    // an untaken skip falls through and the next word runs at once
                    if (take_second)
                    begin
                        nxt_cur.st = MIFD_FLUSH;
                    end
                end

                MIFD_FLUSH:
                begin
                    // prefetched word is dropped, executed as nop
                    // zero fields and flags so no consumer acts on it
                    nxt_cur.flush = 1'b1;
                    nxt_cur.fields = '0;
                    nxt_cur.flags = '0;
                    nxt_cur.st = MIFD_FETCH;
                end

                default:
                begin
                    // an unused state code recovers to a clean fetch
                    nxt_cur.st = MIFD_FETCH;
                end
            endcase
        end

        // ==========================================================
        // status levels
        // the two words cannot coincide, so the order of these tests is free
        // standby clears power-down and sets timeout
        if (standby_go)
        begin
            nxt_cur.power_down_flag = 1'b0;
            nxt_cur.timeout_flag = STATUS_RST;
        end

        // watchdog clear puts both levels back to their power-on state
        if (wdog_go)
        begin
            nxt_cur.power_down_flag = STATUS_RST;
            nxt_cur.timeout_flag = STATUS_RST;
        end
    end

    // ==========================================================
    // state register; status flags come up set as after power-on
    // the reset branch loads constants only, so nothing combinational can
    // reach the flops while nrst_in is low
    always_ff @(posedge mclk_in or negedge nrst_in)
    begin
        if (!nrst_in)
        begin
            cur_ff <= '0;
            cur_ff.st <= MIFD_FETCH;
            cur_ff.timeout_flag <= STATUS_RST;
            cur_ff.power_down_flag <= STATUS_RST;
        end
        else
        begin
            cur_ff <= nxt_cur;
        end
    end

    // ==========================================================
    // outputs straight from flops
    // nothing here is combinational from the inputs, so downstream timing
    // sees a clean flop at every port
    // decoded word, held for the whole instruction cycle
    assign fields_out = cur_ff.fields;
    assign flags_out = cur_ff.flags;

    // one-clock pulses at the end of each instruction cycle
    assign cycle_end_out = cur_ff.cyc_end;
    assign exec_valid_out = cur_ff.exec_valid;
    assign flush_out = cur_ff.flush;
    assign sleep_req_out = cur_ff.sleep_req;
    assign pc_inc_out = cur_ff.pc_inc;

    // status levels, moved only by standby and watchdog clear
    assign timeout_flag_out = cur_ff.timeout_flag;
    assign power_down_flag_out = cur_ff.power_down_flag;
endmodule

// file: hdl/mifd_field_split.sv
// combinational split of one instruction word into fields and flags
`timescale 1ns/1ps
module mifd_field_split
    import mifd_pkg::*;
(
    input wire logic [WORD_W-1:0] word_in,
    output mifd_fields_s fields_out,
    output mifd_flags_s flags_out
);
    logic [1:0] cls;
    logic [3:0] bop;
    logic [1:0] bitop;
    logic [6:0] fa;
    logic writes_f;

    always_comb
    begin
        cls = word_in[CLASS_LSB +: CLASS_W];
        bop = word_in[BYTEOP_LSB +: BYTEOP_W];
        bitop = word_in[BITOP_LSB +: BITOP_W];
        fa = word_in[FADDR_LSB +: FADDR_W];
        // field extraction, unused bits are don't-care
        fields_out.op_class = cls;
        fields_out.file_addr = fa;
        fields_out.dest_file = word_in[DEST_POS];
        fields_out.bit_num = word_in[BITNUM_LSB +: BITNUM_W];
        fields_out.lit8 = word_in[LIT_LSB +: LIT8_W];
        fields_out.lit11 = word_in[LIT_LSB +: LIT11_W];
        // byte ops write f when d is set; bit set/clear always write f
        writes_f = ((cls == CLASS_BYTE) && (bop != BOP_MISC) && word_in[DEST_POS])
            || ((cls == CLASS_BYTE) && (bop == BOP_MISC) && word_in[DEST_POS])
            || ((cls == CLASS_BIT) && !bitop[1]);
        flags_out.is_cond_skip = ((cls == CLASS_BYTE)
            && ((bop == BOP_DEC_SKIP) || (bop == BOP_INC_SKIP)))
            || ((cls == CLASS_BIT) && ((bitop == BITOP_TSTC) || (bitop == BITOP_TSTS)));
        flags_out.is_pc_write = (cls == CLASS_JUMP)
            || ((cls == CLASS_LIT) && (bitop == LOP_RET_LIT))
            || (word_in == W_RETURN) || (word_in == W_IRQ_RET)
            || (writes_f && (fa == FA_PCL));
        flags_out.is_sleep = (word_in == W_SLEEP);
        flags_out.is_wdog_clr = (word_in == W_WDOG_CLR);
        // the direction-write range also covers standby and watchdog clear
        flags_out.is_legacy = (word_in == W_OPTION)
            || (((word_in & LEGACY_DIR_MASK) == LEGACY_DIR_BASE)
            && (word_in != W_SLEEP) && (word_in != W_WDOG_CLR));
        flags_out.use_pins = writes_f && (fa >= FA_PORT_LO) && (fa <= FA_PORT_HI);
        flags_out.clr_prescale = writes_f && (fa == FA_TIMER0);
        flags_out.is_nop = ((word_in & NOP_MASK) == W_NOP);
    end
endmodule

// file: shared/mifd_pkg.sv
// package of field layouts, opcodes and timing constants for the instruction decoder
package mifd_pkg;

    // ==========================================================
    // word and field layout
    localparam int WORD_W = 14;
    localparam int FADDR_W = 7;
    localparam int BITNUM_W = 3;
    localparam int LIT8_W = 8;
    localparam int LIT11_W = 11;
    localparam int FADDR_LSB = 0;
    localparam int BITNUM_LSB = 7;
    localparam int DEST_POS = 7;
    localparam int CLASS_LSB = 12;
    localparam int BYTEOP_LSB = 8;
    localparam int BITOP_LSB = 10;
    localparam int GOTO_POS = 11;
    localparam int CLASS_W = 2;
    localparam int BYTEOP_W = 4;
    localparam int BITOP_W = 2;
    localparam int LIT_LSB = 0;

    // ==========================================================
    // operation class codes in the top two bits
    localparam logic [1:0] CLASS_BYTE = 2'h0;
    localparam logic [1:0] CLASS_BIT = 2'h1;
    localparam logic [1:0] CLASS_JUMP = 2'h2;
    localparam logic [1:0] CLASS_LIT = 2'h3;

    // byte class sub-codes
    localparam logic [3:0] BOP_MISC = 4'h0;
    localparam logic [3:0] BOP_DEC_SKIP = 4'hB;
    localparam logic [3:0] BOP_INC_SKIP = 4'hF;
    // bit class sub-codes
    localparam logic [1:0] BITOP_CLR = 2'h0;
    localparam logic [1:0] BITOP_SET = 2'h1;
    localparam logic [1:0] BITOP_TSTC = 2'h2;
    localparam logic [1:0] BITOP_TSTS = 2'h3;
    // literal class sub-code for return-with-literal (bits 11:10)
    localparam logic [1:0] LOP_RET_LIT = 2'h1;

    // fixed control words
    localparam logic [13:0] W_SLEEP = 14'h0063;
    localparam logic [13:0] W_WDOG_CLR = 14'h0064;
    localparam logic [13:0] W_RETURN = 14'h0008;
    localparam logic [13:0] W_IRQ_RET = 14'h0009;
    localparam logic [13:0] W_NOP = 14'h0000;
    localparam logic [13:0] W_OPTION = 14'h0062;
    localparam logic [13:0] LEGACY_DIR_MASK = 14'h3FF8;
    localparam logic [13:0] LEGACY_DIR_BASE = 14'h0060;
    localparam logic [13:0] NOP_MASK = 14'h3F9F;

    // special file addresses
    localparam logic [6:0] FA_TIMER0 = 7'h01;
    localparam logic [6:0] FA_PCL = 7'h02;
    localparam logic [6:0] FA_PORT_LO = 7'h05;
    localparam logic [6:0] FA_PORT_HI = 7'h09;

    // ==========================================================
    // timing
    localparam int OSC_PER_CYC = 4;
    localparam logic [1:0] PHASE_LAST = 2'(OSC_PER_CYC - 1);
    // power-on level of the timeout and power-down flags
    localparam logic STATUS_RST = 1'b1;

    typedef enum logic [1:0] {
        MIFD_FETCH = 2'b00,
        MIFD_FLUSH = 2'b01
    } mifd_state_e;

    // decoded fields of one instruction
    typedef struct packed {
        logic [1:0] op_class;
        logic [6:0] file_addr;
        logic dest_file;
        logic [2:0] bit_num;
        logic [7:0] lit8;
        logic [10:0] lit11;
    } mifd_fields_s;

    // side-effect flags of one instruction
    typedef struct packed {
        logic is_cond_skip;
        logic is_pc_write;
        logic is_sleep;
        logic is_wdog_clr;
        logic is_legacy;
        logic use_pins;
        logic clr_prescale;
        logic is_nop;
    } mifd_flags_s;

endpackage

// file: testbench/mifd_decoder_props.sv
// concurrent checks on the decoder ports
`timescale 1ns/1ps
module mifd_decoder_props
    import mifd_pkg::*;
(
    input wire logic mclk_in,
    input wire logic nrst_in,
    input wire logic [WORD_W-1:0] instr_in,
    input wire logic cond_true_in,
    input wire logic prescaler_on_timer_in,
    input mifd_fields_s fields_out,
    input mifd_flags_s flags_out,
    input wire logic cycle_end_out,
    input wire logic exec_valid_out,
    input wire logic flush_out,
    input wire logic sleep_req_out,
    input wire logic timeout_flag_out,
    input wire logic power_down_flag_out,
    input wire logic pc_inc_out
);
    // ==========================================================
    // fields are judged against the word sampled one edge earlier
    default clocking cb @(posedge mclk_in);
    endclocking
    default disable iff (!nrst_in);
    sequence s_branch;
        exec_valid_out && flags_out.is_pc_write;
    endsequence
    sequence s_nop_slot;
        !cycle_end_out [*3] ##1 (flush_out && !exec_valid_out);
    endsequence
    a_cycle_four: assert property (cycle_end_out |=> !cycle_end_out [*3] ##1 cycle_end_out)
        else $error("instruction cycle is not four clocks");
    a_result_on_end: assert property (exec_valid_out || flush_out |-> cycle_end_out)
        else $error("result outside a cycle end");
    a_class_field: assert property (exec_valid_out |-> fields_out.op_class == $past(instr_in[13:12]))
        else $error("class field wrong");
    a_addr_field: assert property (exec_valid_out && !fields_out.op_class[1]
        |-> fields_out.file_addr == $past(instr_in[6:0]))
        else $error("file address wrong");
    a_dest_field: assert property (exec_valid_out && fields_out.op_class == CLASS_BYTE
        |-> fields_out.dest_file == $past(instr_in[DEST_POS]))
        else $error("destination wrong");
    a_bit_field: assert property (exec_valid_out && fields_out.op_class == CLASS_BIT
        |-> fields_out.bit_num == $past(instr_in[9:7]))
        else $error("bit number wrong");
    a_jump_lit: assert property (exec_valid_out && fields_out.op_class == CLASS_JUMP
        |-> fields_out.lit11 == $past(instr_in[10:0]))
        else $error("jump target wrong");
    a_branch_flush: assert property (s_branch |=> s_nop_slot)
        else $error("no discard cycle after branch");
    a_flush_clean: assert property (flush_out |-> fields_out == '0 && flags_out == '0)
        else $error("discarded word leaked");
    a_standby_req: assert property (exec_valid_out && $past(instr_in) == W_SLEEP
        |-> sleep_req_out ##[0:1] (!power_down_flag_out && timeout_flag_out))
        else $error("standby not honoured");
    a_skip_flush: assert property (exec_valid_out && flags_out.is_cond_skip
        && $past(cond_true_in) |=> s_nop_slot)
        else $error("no discard cycle after taken skip");
    a_skip_stay: assert property (exec_valid_out && flags_out.is_cond_skip
        && !$past(cond_true_in) |=> !flush_out [*4])
        else $error("untaken skip discarded a word");
    a_pc_step: assert property (cycle_end_out |-> pc_inc_out)
        else $error("no pc step at cycle end");
endmodule
bind mifd_decoder mifd_decoder_props i_mifd_decoder_props
(
    .mclk_in(mclk_in),
    .nrst_in(nrst_in),
    .instr_in(instr_in),
    .cond_true_in(cond_true_in),
    .prescaler_on_timer_in(prescaler_on_timer_in),
    .fields_out(fields_out),
    .flags_out(flags_out),
    .cycle_end_out(cycle_end_out),
    .exec_valid_out(exec_valid_out),
    .flush_out(flush_out),
    .sleep_req_out(sleep_req_out),
    .timeout_flag_out(timeout_flag_out),
    .power_down_flag_out(power_down_flag_out),
    .pc_inc_out(pc_inc_out)
);

// file: testbench/test_mcu_instruction_field_decoder.sv
// self-checking bench for the instruction field decoder
`timescale 1ns/1ps
module test_mcu_instruction_field_decoder
    import mifd_pkg::*;
;
    logic mclk_in = 1'b0;
    logic nrst_in = 1'b0;
    logic [WORD_W-1:0] instr_in = '0;
    logic cond_true_in = 1'b0;
    logic prescaler_on_timer_in = 1'b0;
    mifd_fields_s fields_out;
    mifd_flags_s flags_out;
    logic cycle_end_out, exec_valid_out, flush_out, sleep_req_out;
    logic timeout_flag_out, power_down_flag_out, pc_inc_out;
    int bad_count = 0;
    int n_compared = 0;
    int cyc = 0;
    mifd_decoder i_mifd_decoder
    (
        .mclk_in(mclk_in),
        .nrst_in(nrst_in),
        .instr_in(instr_in),
        .cond_true_in(cond_true_in),
        .prescaler_on_timer_in(prescaler_on_timer_in),
        .fields_out(fields_out),
        .flags_out(flags_out),
        .cycle_end_out(cycle_end_out),
        .exec_valid_out(exec_valid_out),
        .flush_out(flush_out),
        .sleep_req_out(sleep_req_out),
        .timeout_flag_out(timeout_flag_out),
        .power_down_flag_out(power_down_flag_out),
        .pc_inc_out(pc_inc_out)
    );
    // ==========================================================
    // clock, and a ceiling far above the run length of some 120 clocks
    initial
    begin
        forever #10 mclk_in = ~mclk_in;
    end
    always @(posedge mclk_in)
    begin
        cyc <= cyc + 1;
        if (cyc == 3000)
        begin
            bad_count = bad_count + 1;
            report_and_stop();
        end
    end
    task automatic chk(input logic [10:0] got, input logic [10:0] exp);
        n_compared = n_compared + 1;
        if (got !== exp)
        begin
            bad_count = bad_count + 1;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    // present a word just after a boundary; return where its result is settled
    task automatic run(input logic [13:0] w, input logic c, input logic p);
        int n;
        n = 0;
        while (cycle_end_out !== 1'b1 && n < 8)
        begin
            @(negedge mclk_in);
            n = n + 1;
        end
        @(posedge mclk_in);
        instr_in <= w;
        cond_true_in <= c;
        prescaler_on_timer_in <= p;
        repeat (3) @(posedge mclk_in);
        @(negedge mclk_in);
        chk(cycle_end_out, 1'b1);
        chk(pc_inc_out, 1'b1);
    endtask
    task automatic t_fields();
        for (int d = 0; d < 2; d++)
        begin
            run({2'h0, 4'h7, d[0], d ? 7'h7F : 7'h00}, 1'b0, 1'b0);
            chk(fields_out.dest_file, d[0]);
            chk(fields_out.file_addr, d ? 11'h7F : 11'h00);
        end
        for (int b = 0; b < 8; b++)
        begin
            run({CLASS_BIT, BITOP_SET, b[2:0], 7'h15}, 1'b0, 1'b0);
            chk(fields_out.bit_num, b[2:0]);
            chk(fields_out.op_class, CLASS_BIT);
        end
    endtask
    // a taken skip discards the next word; an untaken one does not
    task automatic t_skip();
        for (int c = 0; c < 2; c++)
        begin
            run({CLASS_BIT, BITOP_TSTC, 3'h4, 7'h20}, c[0], 1'b0);
            chk(exec_valid_out, 1'b1);
            chk(flags_out.is_cond_skip, 1'b1);
            run(14'h0A55, 1'b0, 1'b0);
            chk(flush_out, c[0]);
            chk(fields_out.file_addr, c ? 11'h00 : 11'h55);
        end
    endtask
    task automatic t_jump_lit();
        run({CLASS_JUMP, 1'h1, 11'h5A3}, 1'b0, 1'b0);
        chk(fields_out.lit11, 11'h5A3);
        chk(flags_out.is_pc_write, 1'b1);
        run({CLASS_LIT, 4'hF, 8'h3C}, 1'b0, 1'b0);
        chk(exec_valid_out, 1'b0);
        run({CLASS_LIT, 4'h0, 8'hA5}, 1'b0, 1'b0);
        chk(fields_out.lit8, 8'hA5);
        run({CLASS_LIT, 4'h3, 8'hA5}, 1'b0, 1'b0);
        chk(fields_out.lit8, 8'hA5);
        // no-operation with its don't-care bit 6 set
        run(14'h0040, 1'b0, 1'b0);
        chk(flags_out.is_nop, 1'b1);
    endtask
    task automatic t_side();
        run(W_SLEEP, 1'b0, 1'b0);
        chk(sleep_req_out, 1'b1);
        chk(flags_out.is_sleep, 1'b1);
        @(negedge mclk_in);
        chk({timeout_flag_out, power_down_flag_out}, 2'h2);
        // watchdog clear restores both levels and is no legacy word
        run(W_WDOG_CLR, 1'b0, 1'b0);
        chk({timeout_flag_out, power_down_flag_out}, 2'h3);
        chk(flags_out.is_legacy, 1'b0);
        run({2'h0, 4'h8, 1'h1, FA_PORT_LO}, 1'b0, 1'b0);
        chk(flags_out.use_pins, 1'b1);
        run({2'h0, 4'h8, 1'h1, 7'h0C}, 1'b0, 1'b0);
        chk(flags_out.use_pins, 1'b0);
        for (int p = 0; p < 2; p++)
        begin
            run({2'h0, 4'h0, 1'h1, FA_TIMER0}, 1'b0, p[0]);
            chk(flags_out.clr_prescale, p[0]);
        end
        run(W_OPTION, 1'b0, 1'b0);
        chk(flags_out.is_legacy, 1'b1);
        // direction write to file 5
        run(14'h0065, 1'b0, 1'b0);
        chk(flags_out.is_legacy, 1'b1);
    endtask
    task automatic report_and_stop();
        $display("compared %0d, mismatches %0d", n_compared, bad_count);
        if (bad_count == 0 && n_compared > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask
    initial
    begin
        repeat (5) @(posedge mclk_in);
        nrst_in <= 1'b1;
        @(negedge mclk_in);
        chk({timeout_flag_out, power_down_flag_out}, 2'h3);
        t_fields();
        t_skip();
        t_jump_lit();
        t_side();
        report_and_stop();
    end
endmodule
